// >>> core/tmr2_consts.svh
`ifndef TMR2_CONSTS_SVH
`define TMR2_CONSTS_SVH

// Register indices, byte address is four times the index
`define TMR2_IDX_CTRLB   6'h0b
`define TMR2_IDX_COUNT   6'h0c
`define TMR2_IDX_RELOAD  6'h0d
`define TMR2_IDX_CFG     6'h10
`define TMR2_IDX_CMP     6'h11
`define TMR2_IDX_LCMP    6'h12
`define TMR2_IDX_HIGH    6'h13
`define TMR2_IDX_STAT    6'h14
`define TMR2_IDX_MASK    6'h15

// Secondary control bit positions
`define TMR2_B_LCMP      0
`define TMR2_B_CAPCMP    1
`define TMR2_B_LOVF      2
`define TMR2_B_OVF       3
`define TMR2_B_POL       5
`define TMR2_B_OE        6
`define TMR2_B_LIE       7
`define TMR2_B_RSVD_MSK  8'hef

// Configuration bit positions
`define TMR2_C_DUAL      0
`define TMR2_C_RUN       1
`define TMR2_C_CAPEN     2

// Event groups inside the status layout
`define TMR2_EV_LOW_MSK  4'h5
`define TMR2_EV_MAIN_MSK 4'ha

// Values
`define TMR2_RST8        8'h00
`define TMR2_RST16       16'h0000
`define TMR2_RST32       32'h0000_0000
`define TMR2_MAX8        8'hff
`define TMR2_MAX16       16'hffff
`define TMR2_ONE8        8'h01
`define TMR2_ONE16       16'h0001
`define TMR2_RESP_OKAY   2'h0
`define TMR2_RESP_SLVERR 2'h2

`endif

// >>> core/tmr2_edge_sync.sv
`include "tmr2_consts.svh"

module tmr2_edge_sync (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  // Pin and pulse
  input  wire logic pin_in,
  output logic      rise_out
);

  tmr2_pkg::tmr2_sync_s s_r;
  tmr2_pkg::tmr2_sync_s s_nxt;

  // First stage is read only by the second
  always_comb begin
    s_nxt         = s_r;
    s_nxt.edge_q1 = pin_in;
    s_nxt.edge_q2 = s_r.edge_q1;
    s_nxt.edge_q3 = s_r.edge_q2;
    s_nxt.rise    = s_r.edge_q2 & ~s_r.edge_q3;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rise_out = s_r.rise;

endmodule // tmr2_edge_sync

// >>> core/tmr2_pkg.sv
package tmr2_pkg;

  typedef enum logic [1:0] {
    TMR2_WR_IDLE = 2'h1,
    TMR2_WR_RESP = 2'h2
  } tmr2_wr_e;

  typedef struct packed {
    tmr2_wr_e    wr_st;
    logic        aw_full;
    logic [7:0]  aw_addr;
    logic        w_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        aw_rdy;
    logic        w_rdy;
    logic        b_vld;
    logic [1:0]  b_resp;
    logic        ar_rdy;
    logic        r_vld;
    logic [31:0] r_data;
    logic [1:0]  r_resp;
    logic [7:0]  ctrlb;
    logic [15:0] count;
    logic [15:0] reload;
    logic [15:0] cmp;
    logic [7:0]  lcmp;
    logic [2:0]  cfg;
    logic [3:0]  stat;
    logic [3:0]  mask;
    logic        oe_q;
    logic        pin;
    logic        irq;
  } tmr2_state_s;

  typedef struct packed {
    logic        edge_q1;
    logic        edge_q2;
    logic        edge_q3;
    logic        rise;
  } tmr2_sync_s;

endpackage : tmr2_pkg

// >>> core/tmr2_timer.sv
// Register access over AXI4-Lite is this design's own decision.
`include "tmr2_consts.svh"

module tmr2_timer (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // Timer pins
  input  wire logic        capture_edge_in,
  output logic             alt_pin_out,
  output logic             alt_pin_oe_out,
  // Interrupt
  output logic             irq_out
);

  tmr2_pkg::tmr2_state_s s_r;
  tmr2_pkg::tmr2_state_s s_nxt;

  logic        cap_rise;
  logic        dual;
  logic        run;
  logic        do_wr;
  logic [5:0]  wr_idx;
  logic [5:0]  rd_idx;
  logic        rd_take;
  logic        ev_lcmp;
  logic        ev_capcmp;
  logic        ev_lovf;
  logic        ev_ovf;
  logic        match16;
  logic        src_evt;
  logic [31:0] rd_val;
  logic        rd_hit;
  logic        wr_hit;
  logic [3:0]  ev_vec;

  tmr2_edge_sync u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .pin_in     (capture_edge_in),
    .rise_out   (cap_rise)
  );

  always_comb begin
    s_nxt  = s_r;
    dual   = s_r.cfg[`TMR2_C_DUAL];
    run    = s_r.cfg[`TMR2_C_RUN];
    wr_idx = s_r.aw_addr[7:2];
    rd_idx = s_axi_araddr_in[7:2];
    do_wr  = (s_r.wr_st == tmr2_pkg::TMR2_WR_IDLE) && s_r.aw_full
             && s_r.w_full;
    rd_take = s_axi_arvalid_in && s_r.ar_rdy;

    // Timer events from the current count and the capture edge
    match16   = (s_r.count == s_r.cmp);
    // low compare only in dual mode
    ev_lcmp   = run && dual && (s_r.count[7:0] == s_r.lcmp);
    ev_capcmp = (run && (dual ? (s_r.count[15:8] == s_r.cmp[15:8])
                              : match16))
                || (s_r.cfg[`TMR2_C_CAPEN] && cap_rise);
    // low timer overflow in dual mode
    ev_lovf   = run && dual && (s_r.count[7:0] == `TMR2_MAX8);
    ev_ovf    = run && (dual ? (s_r.count[15:8] == `TMR2_MAX8)
                             : (s_r.count == `TMR2_MAX16));
    src_evt   = dual ? (ev_lcmp || ev_lovf)
                     : (ev_ovf || (run && match16));
    ev_vec    = {ev_ovf, ev_lovf, ev_capcmp, ev_lcmp};

    // Counting
    if (run) begin
      if (dual) begin
        s_nxt.count[7:0]  = ev_lovf ? s_r.reload[7:0]
                                    : s_r.count[7:0] + `TMR2_ONE8;
        s_nxt.count[15:8] = ev_ovf ? s_r.reload[15:8]
                                   : s_r.count[15:8] + `TMR2_ONE8;
      end else begin
        s_nxt.count = ev_ovf ? s_r.reload : s_r.count + `TMR2_ONE16;
      end
    end
    if (s_r.cfg[`TMR2_C_CAPEN] && cap_rise) begin
      s_nxt.cmp = dual ? {s_r.count[15:8], s_r.cmp[7:0]} : s_r.count;
    end

    // Write channels
    if (s_axi_awvalid_in && s_r.aw_rdy) begin
      s_nxt.aw_full = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_r.w_rdy) begin
      s_nxt.w_full = 1'b1;
      s_nxt.w_data = s_axi_wdata_in;
      s_nxt.w_strb = s_axi_wstrb_in;
    end
    if ((s_r.wr_st == tmr2_pkg::TMR2_WR_RESP) && s_axi_bready_in) begin
      s_nxt.b_vld = 1'b0;
      s_nxt.wr_st = tmr2_pkg::TMR2_WR_IDLE;
    end
    wr_hit = 1'b1;
    if (do_wr) begin
      s_nxt.aw_full = 1'b0;
      s_nxt.w_full  = 1'b0;
      s_nxt.b_vld   = 1'b1;
      s_nxt.wr_st   = tmr2_pkg::TMR2_WR_RESP;
      case (wr_idx)
        `TMR2_IDX_CTRLB: begin
          if (s_r.w_strb[0]) begin
            s_nxt.ctrlb = s_r.w_data[7:0] & `TMR2_B_RSVD_MSK;
          end
        end
        `TMR2_IDX_COUNT: begin
          // upper byte only in 16-bit mode
          if (s_r.w_strb[0]) begin
            s_nxt.count[7:0] = s_r.w_data[7:0];
          end
          if (s_r.w_strb[1] && !dual) begin
            s_nxt.count[15:8] = s_r.w_data[15:8];
          end
        end
        `TMR2_IDX_RELOAD: begin
          // upper byte blocked in dual mode
          if (s_r.w_strb[0]) begin
            s_nxt.reload[7:0] = s_r.w_data[7:0];
          end
          if (s_r.w_strb[1] && !dual) begin
            s_nxt.reload[15:8] = s_r.w_data[15:8];
          end
        end
        `TMR2_IDX_CFG: begin
          if (s_r.w_strb[0]) begin
            s_nxt.cfg = s_r.w_data[2:0];
          end
        end
        `TMR2_IDX_CMP: begin
          if (s_r.w_strb[0]) begin
            s_nxt.cmp[7:0] = s_r.w_data[7:0];
          end
          if (s_r.w_strb[1]) begin
            s_nxt.cmp[15:8] = s_r.w_data[15:8];
          end
        end
        `TMR2_IDX_LCMP: begin
          if (s_r.w_strb[0]) begin
            s_nxt.lcmp = s_r.w_data[7:0];
          end
        end
        `TMR2_IDX_HIGH: begin
          // high count and high reload bytes
          if (s_r.w_strb[0]) begin
            s_nxt.count[15:8] = s_r.w_data[7:0];
          end
          if (s_r.w_strb[1]) begin
            s_nxt.reload[15:8] = s_r.w_data[15:8];
          end
        end
        `TMR2_IDX_STAT: begin
        end
        `TMR2_IDX_MASK: begin
          if (s_r.w_strb[0]) begin
            s_nxt.mask = s_r.w_data[3:0];
          end
        end
        default: begin
          wr_hit = 1'b0;
        end
      endcase
      s_nxt.b_resp = wr_hit ? `TMR2_RESP_OKAY : `TMR2_RESP_SLVERR;
    end

    // flags set by hardware, set wins over a written zero
    s_nxt.ctrlb[3:0] = s_nxt.ctrlb[3:0] | ev_vec;

    // Read channel
    rd_hit = 1'b1;
    case (rd_idx)
      `TMR2_IDX_CTRLB:  rd_val = {24'h0, s_r.ctrlb & `TMR2_B_RSVD_MSK};
      // upper byte hidden in dual mode
      `TMR2_IDX_COUNT:  rd_val = {16'h0, dual ? 8'h00 : s_r.count[15:8],
                                  s_r.count[7:0]};
      // upper byte hidden in dual mode
      `TMR2_IDX_RELOAD: rd_val = {16'h0, dual ? 8'h00 : s_r.reload[15:8],
                                  s_r.reload[7:0]};
      `TMR2_IDX_CFG:    rd_val = {29'h0, s_r.cfg};
      `TMR2_IDX_CMP:    rd_val = {16'h0, s_r.cmp};
      `TMR2_IDX_LCMP:   rd_val = {24'h0, s_r.lcmp};
      `TMR2_IDX_HIGH:   rd_val = {16'h0, s_r.reload[15:8], s_r.count[15:8]};
      `TMR2_IDX_STAT:   rd_val = {28'h0, s_r.stat};
      `TMR2_IDX_MASK:   rd_val = {28'h0, s_r.mask};
      default: begin
        rd_val = `TMR2_RST32;
        rd_hit = 1'b0;
      end
    endcase
    if (s_r.r_vld && s_axi_rready_in) begin
      s_nxt.r_vld = 1'b0;
    end
    if (rd_take) begin
      s_nxt.r_vld  = 1'b1;
      s_nxt.r_data = rd_val;
      s_nxt.r_resp = rd_hit ? `TMR2_RESP_OKAY : `TMR2_RESP_SLVERR;
    end

    // Status: read clears, new events win
    if (rd_take && (rd_idx == `TMR2_IDX_STAT)) begin
      s_nxt.stat = ev_vec;
    end else begin
      s_nxt.stat = s_r.stat | ev_vec;
    end

    s_nxt.oe_q = s_nxt.ctrlb[`TMR2_B_OE];
    // polarity loaded only on enable rising
    if (s_nxt.ctrlb[`TMR2_B_OE] && !s_r.oe_q) begin
      s_nxt.pin = s_nxt.ctrlb[`TMR2_B_POL];
    end else if (s_r.oe_q && src_evt) begin
      s_nxt.pin = ~s_r.pin;
    end

    // low sources gated, set low flags keep requesting
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask &
                  ({4{s_nxt.ctrlb[`TMR2_B_LIE]}} | `TMR2_EV_MAIN_MSK))
                || (s_nxt.ctrlb[`TMR2_B_LIE]
                    && |(s_nxt.ctrlb[3:0] & s_nxt.mask & `TMR2_EV_LOW_MSK));

    s_nxt.aw_rdy = !s_nxt.aw_full;
    s_nxt.w_rdy  = !s_nxt.w_full;
    s_nxt.ar_rdy = !s_nxt.r_vld;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s_r       <= '0;
      s_r.wr_st <= tmr2_pkg::TMR2_WR_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready_out = s_r.aw_rdy;
  assign s_axi_wready_out  = s_r.w_rdy;
  assign s_axi_bvalid_out  = s_r.b_vld;
  assign s_axi_bresp_out   = s_r.b_resp;
  assign s_axi_arready_out = s_r.ar_rdy;
  assign s_axi_rvalid_out  = s_r.r_vld;
  assign s_axi_rdata_out   = s_r.r_data;
  assign s_axi_rresp_out   = s_r.r_resp;
  assign alt_pin_out       = s_r.pin;
  assign alt_pin_oe_out    = s_r.oe_q;
  assign irq_out           = s_r.irq;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  chk_rsvd_reads_zero: assert property (
    rd_take && (rd_idx == `TMR2_IDX_CTRLB) |=> !s_axi_rdata_out[4])
    else $error("reserved control bit read as one");

  chk_low_cmp_flag: assert property (
    ev_lcmp |=> s_r.ctrlb[`TMR2_B_LCMP])
    else $error("low compare flag not set");

  chk_no_low_cmp_wide: assert property (
    !dual && !s_r.ctrlb[`TMR2_B_LCMP] && !(do_wr && wr_idx == `TMR2_IDX_CTRLB)
    |=> !s_r.ctrlb[`TMR2_B_LCMP])
    else $error("low compare flag set in 16-bit mode");

  chk_wide_cmp_flag: assert property (
    run && !dual && (s_r.count == s_r.cmp) |=> s_r.ctrlb[`TMR2_B_CAPCMP])
    else $error("compare flag not set on full match");

  chk_low_ovf_reload: assert property (
    ev_lovf && !do_wr
    |=> s_r.ctrlb[`TMR2_B_LOVF] && (s_r.count[7:0] == $past(s_r.reload[7:0])))
    else $error("low overflow not flagged or reloaded");

  chk_wide_ovf_reload: assert property (
    run && !dual && (s_r.count == `TMR2_MAX16) && !do_wr
    |=> s_r.ctrlb[`TMR2_B_OVF] && (s_r.count == $past(s_r.reload)))
    else $error("full overflow not flagged or reloaded");

  chk_pin_start_level: assert property (
    $rose(alt_pin_oe_out) |-> (alt_pin_out == s_r.ctrlb[`TMR2_B_POL]))
    else $error("pin start level differs from polarity");

  chk_pin_holds_level: assert property (
    s_r.oe_q && !src_evt && s_nxt.ctrlb[`TMR2_B_OE] |=> $stable(alt_pin_out))
    else $error("pin changed without timer event");

  chk_low_irq_gated: assert property (
    irq_out && !s_r.ctrlb[`TMR2_B_LIE]
    |-> |(s_r.stat & s_r.mask & `TMR2_EV_MAIN_MSK))
    else $error("low source requested while gated");

  chk_value_write: assert property (
    do_wr && (wr_idx == `TMR2_IDX_COUNT) && !dual && (&s_r.w_strb[1:0])
    |=> s_r.count == $past(s_r.w_data[15:0]))
    else $error("value write lost");

  chk_dual_value_read: assert property (
    rd_take && dual && (rd_idx == `TMR2_IDX_COUNT)
    |=> s_axi_rdata_out[15:8] == 8'h00)
    else $error("value upper byte visible in dual mode");

  chk_dual_reload_read: assert property (
    rd_take && dual && (rd_idx == `TMR2_IDX_RELOAD)
    |=> s_axi_rdata_out[15:8] == 8'h00)
    else $error("reload upper byte visible in dual mode");

  chk_flag_sticky: assert property (
    s_r.ctrlb[`TMR2_B_OVF] && !(do_wr && wr_idx == `TMR2_IDX_CTRLB)
    |=> s_r.ctrlb[`TMR2_B_OVF])
    else $error("overflow flag dropped without write");

  chk_oe_follows_bit: assert property (
    do_wr && (wr_idx == `TMR2_IDX_CTRLB) && s_r.w_strb[0]
    |=> alt_pin_oe_out == $past(s_r.w_data[`TMR2_B_OE]))
    else $error("pin enable does not follow control bit");

  chk_bvalid_holds: assert property (
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write response dropped early");

  cov_wide_ovf: cover property (run && !dual && ev_ovf);
  cov_low_ovf: cover property (ev_lovf);
  cov_capture: cover property (s_r.cfg[`TMR2_C_CAPEN] && cap_rise);
  cov_pin_enable: cover property ($rose(alt_pin_oe_out));
  cov_irq: cover property ($rose(irq_out));

endmodule // tmr2_timer

// >>> testbench/testbench.sv
`include "tmr2_consts.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] A_CTL  = {`TMR2_IDX_CTRLB, 2'b00};
  localparam logic [7:0] A_CNT  = {`TMR2_IDX_COUNT, 2'b00};
  localparam logic [7:0] A_RLD  = {`TMR2_IDX_RELOAD, 2'b00};
  localparam logic [7:0] A_CFG  = {`TMR2_IDX_CFG, 2'b00};
  localparam logic [7:0] A_CMP  = {`TMR2_IDX_CMP, 2'b00};
  localparam logic [7:0] A_LCMP = {`TMR2_IDX_LCMP, 2'b00};
  localparam logic [7:0] A_HIGH = {`TMR2_IDX_HIGH, 2'b00};
  localparam logic [7:0] A_STAT = {`TMR2_IDX_STAT, 2'b00};
  localparam logic [7:0] A_MASK = {`TMR2_IDX_MASK, 2'b00};

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        arvalid = 1'b0;
  logic        bready = 1'b1;
  logic        rready = 1'b1;
  logic        pulse = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        pin, pin_oe, irq, cap;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, v, a, b, c, d;
  logic [7:0]  tog, t0;
  logic [31:0] seed = 32'h59552c0b;
  int          bad_count = 0;
  int          compares = 0;

  always #5 clk = ~clk;

  tmr2_timer uut (
    .clk_sys_in(clk), .rst_in(rst),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .capture_edge_in(cap),
    .alt_pin_out(pin), .alt_pin_oe_out(pin_oe), .irq_out(irq));

  tmr2_pin_model pm (
    .clk_sys_in(clk), .rst_in(rst), .pulse_in(pulse),
    .capture_edge_out(cap), .alt_pin_in(pin),
    .alt_pin_oe_in(pin_oe), .toggles_out(tog));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Ready lines stay high, so only valid lines move
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    int n;
    n = 0;
    awaddr <= ad;
    wdata <= dt;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
      if (n > 200) begin
        chk(32'h1, 32'h0);
        break;
      end
    end
    resp = bresp;
  endtask

  task automatic rd(input logic [7:0] ad);
    int n;
    n = 0;
    araddr <= ad;
    arvalid <= 1'b1;
    forever begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
      if (n > 200) begin
        chk(32'h1, 32'h0);
        break;
      end
    end
    v = rdata;
    resp = rresp;
  endtask

  task automatic rc(input logic [7:0] ad, input logic [31:0] e);
    rd(ad);
    chk(v, e);
  endtask

  task automatic poll(input logic [7:0] m);
    int n;
    n = 0;
    do begin
      rd(A_CTL);
      n++;
    end while ((v[7:0] & m) !== m && n < 80);
    chk(32'(v[7:0] & m), 32'(m));
  endtask

  task automatic zero_chk();
    rd(A_CTL);
    chk(v, 32'h0);
    rc(A_CNT, 32'h0);
    rc(A_RLD, 32'h0);
  endtask

  task give_verdict;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end

  initial begin
    tick(2);
    rst <= 1'b0;
    tick(2);
    zero_chk();
    rd(8'h00);
    chk({30'h0, resp}, {30'h0, `TMR2_RESP_SLVERR});
    wr(8'hfc, 32'h1);
    chk({30'h0, resp}, {30'h0, `TMR2_RESP_SLVERR});
    repeat (4) begin
      a = rnd();
      wr(A_CNT, a);
      wr(A_RLD, ~a);
      rc(A_CNT, {16'h0, a[15:0]});
      rc(A_RLD, {16'h0, ~a[15:0]});
    end
    a = rnd();
    b = rnd();
    c = rnd();
    d = rnd();
    wr(A_CNT, a);
    wr(A_RLD, b);
    wr(A_CFG, 32'h1);
    wr(A_CNT, c);
    wr(A_RLD, d);
    rc(A_CNT, {24'h0, c[7:0]});
    rc(A_RLD, {24'h0, d[7:0]});
    wr(A_CFG, 32'h0);
    rc(A_CNT, {16'h0, a[15:8], c[7:0]});
    rc(A_RLD, {16'h0, b[15:8], d[7:0]});
    wr(A_CTL, 32'h1f);
    rc(A_CTL, 32'h0f);
    wr(A_CTL, 32'h0);
    rc(A_CTL, 32'h0);
    wr(A_CTL, 32'h20);
    tick(2);
    chk(32'(pin_oe), 32'h0);
    wr(A_CTL, 32'h60);
    tick(2);
    chk(32'({pin_oe, pin}), 32'h3);
    wr(A_CTL, 32'h40);
    tick(2);
    chk(32'(pin), 32'h1);
    wr(A_CTL, 32'h0);
    tick(2);
    chk(32'(pin_oe), 32'h0);
    wr(A_CTL, 32'h40);
    tick(2);
    chk(32'({pin_oe, pin}), 32'h2);
    wr(A_LCMP, 32'hf8);
    wr(A_CMP, 32'hfff4);
    wr(A_RLD, 32'hfff0);
    wr(A_CNT, 32'hfff0);
    t0 = tog;
    wr(A_CFG, 32'h2);
    poll(8'h0a);
    wr(A_CFG, 32'h0);
    wr(A_CNT, 32'h0);
    rd(A_CTL);
    chk(v & 32'h5, 32'h0);
    chk(32'(tog != t0), 32'h1);
    wr(A_MASK, 32'h5);
    wr(A_CTL, 32'h0);
    rd(A_STAT);
    wr(A_CNT, 32'hf0);
    wr(A_CFG, 32'h3);
    poll(8'h05);
    wr(A_CFG, 32'h0);
    wr(A_CNT, 32'h0);
    tick(3);
    chk(32'(irq), 32'h0);
    rd(A_STAT);
    chk(v & 32'h5, 32'h5);
    wr(A_CTL, 32'h85);
    tick(3);
    chk(32'(irq), 32'h1);
    wr(A_MASK, 32'h0);
    tick(3);
    chk(32'(irq), 32'h0);
    wr(A_MASK, 32'h5);
    wr(A_CTL, 32'h80);
    tick(3);
    chk(32'(irq), 32'h0);
    wr(A_CTL, 32'h0);
    // High byte reached through its own register in dual mode
    wr(A_CFG, 32'h1);
    wr(A_HIGH, 32'h12fe);
    rc(A_HIGH, 32'h12fe);
    rc(A_CNT, 32'h0);
    wr(A_CFG, 32'h3);
    poll(8'h0a);
    wr(A_CFG, 32'h0);
    wr(A_CTL, 32'h0);
    a = rnd();
    wr(A_CNT, a);
    wr(A_CFG, 32'h4);
    pulse <= 1'b1;
    tick(1);
    pulse <= 1'b0;
    poll(8'h02);
    rc(A_CMP, {16'h0, a[15:0]});
    wr(A_CTL, 32'h6f);
    wr(A_RLD, a);
    wr(A_CFG, 32'h2);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(2);
    zero_chk();
    give_verdict();
  end
endmodule // testbench

// >>> testbench/tmr2_pin_model.sv
module tmr2_pin_model (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // Bench request
  input  wire logic       pulse_in,
  // Timer pins
  output logic            capture_edge_out,
  input  wire logic       alt_pin_in,
  input  wire logic       alt_pin_oe_in,
  // Observed pin activity
  output logic [7:0]      toggles_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] hold_r;
  logic       last_r;

  // Edge held long enough for the input synchroniser
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      hold_r           <= 4'h0;
      capture_edge_out <= 1'b0;
      last_r           <= 1'b0;
      toggles_out      <= 8'h00;
    end else begin
      if (pulse_in && hold_r == 4'h0) begin
        hold_r <= 4'h8;
      end else if (hold_r != 4'h0) begin
        hold_r <= hold_r - 4'h1;
      end
      capture_edge_out <= (hold_r != 4'h0);
      last_r           <= alt_pin_in;
      if (alt_pin_oe_in && alt_pin_in !== last_r) begin
        toggles_out <= toggles_out + 8'h01;
      end
    end
  end
endmodule // tmr2_pin_model
